// ===== hdl/sxc_ctrl.sv
// controller for an asynchronous 8M x 8 static memory, driving its pins
// assumes one 200 MHz clock, the memory wired straight to the pin ports
// one byte per request; windows never run back to back, idle pins follow each one
// limitation: the data pin driver lives outside, fed by data_bus_out and data_bus_oe
`timescale 1ns/10ps
module sxc_ctrl
    import sxc_pkg::*;
#(
    parameter int POWERUP_CYC = POWERUP_CYC_DEF
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // user request side
    input  wire logic              req_valid,
    input  wire sxc_pkg::sxc_req_t req,
    output logic                   req_ready,
    output logic                   rd_valid,
    output logic [sxc_pkg::DATA_W-1:0] rd_data,
    // memory pins
    output sxc_pkg::sxc_pins_t     pins,
    input  wire logic [sxc_pkg::DATA_W-1:0] data_bus_in,
    output logic [sxc_pkg::DATA_W-1:0] data_bus_out,
    output logic                   data_bus_oe
);
    import sxc_pkg::*;

    // ------------------------------------------------------------
    // pin input synchroniser, three stages
    // ------------------------------------------------------------
    logic [DATA_W-1:0] din_s1_r, din_s2_r, din_s3_r;
    logic              din_agree;

    // stage 1 may be metastable, so only stage 2 reads it
    always_ff @(posedge clk) begin
        din_s1_r <= data_bus_in;
        din_s2_r <= din_s1_r;
        din_s3_r <= din_s2_r;
    end

    // a read value counts once stages 2 and 3 agree
    assign din_agree = (din_s2_r == din_s3_r);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    sxc_state_t        st_r, st_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    sxc_pins_t         pins_r, pins_nxt;
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic              oe_r, oe_nxt;
    logic              rdy_r, rdy_nxt;
    logic              rv_r, rv_nxt;
    logic [DATA_W-1:0] rd_r, rd_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // idle pins: deselected both ways so the memory sits in standby
    function automatic sxc_pins_t idle_pins(input logic [ADDR_W-1:0] a);
        sxc_pins_t p;
        p.chip_select_low  = 1'b1;
        p.chip_select_high = 1'b0;
        p.output_enable_n  = 1'b1;
        p.write_enable_n   = 1'b1;
        p.address_bus      = a;
        return p;
    endfunction

    // end-of-count test shared by every timed state; counts never go negative
    function automatic logic cnt_reached(input logic [CNT_W-1:0] c, input int last);
        return 32'(c) >= last;
    endfunction

    // write: window of WRITE_CYC cycles, then GAP_CYC cycles of idle pins
    // read: READ_CYC access plus two synchroniser stages before the capture
    // next-state logic
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        pins_nxt = pins_r;
        dout_nxt = dout_r;
        oe_nxt   = oe_r;
        rdy_nxt  = 1'b0;
        rv_nxt   = 1'b0;
        rd_nxt   = rd_r;
        case (st_r)
            ST_POWERUP: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_reached(cnt_r, POWERUP_CYC - 1)) begin
                    st_nxt  = ST_IDLE;
                    rdy_nxt = 1'b1;
                end
            end
            // take one request per cycle of shown ready
            ST_IDLE: begin
                rdy_nxt = 1'b1;
                if (req_valid && rdy_r) begin
                    rdy_nxt = 1'b0;
                    cnt_nxt = CNT_RESET;
                    pins_nxt.address_bus = req.addr;
                    pins_nxt.chip_select_low  = 1'b0;
                    pins_nxt.chip_select_high = 1'b1;
                    if (req.write) begin
                        pins_nxt.write_enable_n = 1'b0;
                        pins_nxt.output_enable_n = 1'b1;
                        dout_nxt = req.wdata;
                        oe_nxt   = 1'b1;
                        st_nxt   = ST_WRITE;
                    end else begin
                        pins_nxt.output_enable_n = 1'b0;
                        pins_nxt.write_enable_n  = 1'b1;
                        oe_nxt = 1'b0;
                        st_nxt = ST_READ;
                    end
                end
            end
            ST_READ: begin
                cnt_nxt = cnt_r + 16'h0001;
                // capture on agreement; a bus that never settles is taken a cycle late instead of hanging
                if (cnt_reached(cnt_r, READ_CYC + 1) && (din_agree || cnt_reached(cnt_r, READ_CYC + 2))) begin
                    rv_nxt   = 1'b1;
                    rd_nxt   = din_s3_r;
                    pins_nxt = idle_pins(pins_r.address_bus);
                    cnt_nxt  = CNT_RESET;
                    st_nxt   = ST_GAP;
                end
            end
            ST_WRITE: begin
                cnt_nxt = cnt_r + 16'h0001;
                // window long enough for write setup and for turn-off plus data setup
                if (cnt_reached(cnt_r, WRITE_CYC - 1)) begin
                    // all strobes drop together, address kept
                    pins_nxt = idle_pins(pins_r.address_bus);
                    cnt_nxt  = CNT_RESET;
                    st_nxt   = ST_GAP;
                end
            end
            ST_GAP: begin
                oe_nxt  = 1'b0; // release one cycle after the window, zero hold met
                // gap counts from window end, so spacing holds for reads and writes alike
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_reached(cnt_r, GAP_CYC - 1)) begin
                    st_nxt  = ST_IDLE;
                    rdy_nxt = 1'b1;
                end
            end
            // illegal code: restart the power-up wait, the safe choice
            default: begin
                st_nxt   = ST_POWERUP;
                cnt_nxt  = CNT_RESET;
                pins_nxt = idle_pins({ADDR_W{1'b0}});
                oe_nxt   = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // plain registering; every decision sits in the next-state logic
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r   <= ST_POWERUP;
            cnt_r  <= CNT_RESET;
            pins_r <= idle_pins({ADDR_W{1'b0}});
            dout_r <= 8'h00;
            oe_r   <= 1'b0;
            rdy_r  <= 1'b0;
            rv_r   <= 1'b0;
            rd_r   <= 8'h00;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            pins_r <= pins_nxt;
            dout_r <= dout_nxt;
            oe_r   <= oe_nxt;
            rdy_r  <= rdy_nxt;
            rv_r   <= rv_nxt;
            rd_r   <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pins change only at edges, so window edges lie whole periods apart
    // outputs straight from flops
    assign pins         = pins_r;
    assign data_bus_out = dout_r;
    assign data_bus_oe  = oe_r;
    assign req_ready    = rdy_r;
    assign rd_valid     = rv_r;
    assign rd_data      = rd_r;

endmodule

// ===== hdl/sxc_pkg.sv
// package for the static memory controller: timing, pin bundles, states
// assumes a 200 MHz clock driving the controller
package sxc_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // timing in printed units, and cycle counts derived from them
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int ADDRESS_ACCESS_NS = 12;
    localparam int OE_ACCESS_NS      = 7;
    localparam int WRITE_SETUP_NS    = 9;
    localparam int DATA_SETUP_NS     = 7;
    localparam int TURNOFF_NS        = 7;
    localparam int CYCLE_TIME_NS     = 12;
    localparam int POWERUP_WAIT_US   = 100;

    // least times round up
    localparam int READ_CYC  = (ADDRESS_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int WRITE_CYC = ((WRITE_SETUP_NS > TURNOFF_NS + DATA_SETUP_NS ? WRITE_SETUP_NS
                               : TURNOFF_NS + DATA_SETUP_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_CYC   = (CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERUP_CYC_DEF = (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // bundles and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sxc_req_t;

    typedef struct packed {
        logic              chip_select_low;
        logic              chip_select_high;
        logic              output_enable_n;
        logic              write_enable_n;
        logic [ADDR_W-1:0] address_bus;
    } sxc_pins_t;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_GAP
    } sxc_state_t;

endpackage

// ===== testbench/sxc_chk.sv
// checker: pin sequencing of the memory controller
// assumes binding onto sxc_ctrl, one clock domain
`timescale 1ns/10ps
module sxc_chk
    import sxc_pkg::*;
#(
    parameter int POWERUP_CYC = 4
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // request side
    input wire logic              req_valid,
    input wire sxc_pkg::sxc_req_t req,
    input wire logic              req_ready,
    input wire logic              rd_valid,
    // memory side
    input wire sxc_pkg::sxc_pins_t pins,
    input wire logic [7:0]        data_bus_out,
    input wire logic              data_bus_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] up_r;
    logic [15:0] up_nxt;
    logic        sel;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    assign sel = !pins.chip_select_low && pins.chip_select_high;
    // edges since reset, saturating so it never wraps
    always_comb up_nxt = (up_r == 16'hFFFF) ? up_r : up_r + 16'h0001;
    always_ff @(posedge clk) up_r <= reset_n ? up_nxt : 16'h0000;
    sequence take_wr; req_valid && req_ready && req.write; endsequence
    sequence take_rd; req_valid && req_ready && !req.write; endsequence
    wait_up_a: assert property (req_ready |-> up_r >= POWERUP_CYC)
        else $error("ready before power-up wait");
    wr_start_a: assert property (take_wr |=> sel && !pins.write_enable_n && pins.output_enable_n
        && data_bus_oe && pins.address_bus == $past(req.addr) && data_bus_out == $past(req.wdata))
        else $error("write start wrong");
    sequence wr_window; (!pins.write_enable_n && sel)[*3] ##1 (pins.write_enable_n && !sel); endsequence
    wr_len_a: assert property (take_wr |=> wr_window)
        else $error("write window length");
    addr_hold_a: assert property (!pins.write_enable_n |=> $stable(pins.address_bus))
        else $error("address moved in window");
    data_hold_a: assert property ($rose(pins.write_enable_n) |-> data_bus_oe && $stable(data_bus_out))
        else $error("write data not held");
    rd_start_a: assert property (take_rd |=> sel && !pins.output_enable_n && pins.write_enable_n)
        else $error("read start wrong");
    rd_done_a: assert property (take_rd |-> ##7 rd_valid ##1 !rd_valid)
        else $error("read data timing");
    no_fight_a: assert property (!pins.output_enable_n |-> !data_bus_oe)
        else $error("bus driven during read");
    cycle_gap_a: assert property ($rose(pins.chip_select_low) |-> pins.chip_select_low[*3])
        else $error("cycles too close");
endmodule
bind sxc_ctrl sxc_chk #(.POWERUP_CYC(POWERUP_CYC)) u_chk (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .pins(pins),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

// ===== testbench/sxc_mem_model.sv
// behavioural 8M x 8 asynchronous static memory
// assumes the bench resolves the shared data wire
`timescale 1ns/10ps
module sxc_mem_model
    import sxc_pkg::*;
#(
    parameter int DLY_NS = 3
) (
    input wire sxc_pkg::sxc_pins_t pins,
    input wire logic [7:0]         dq_in,
    output logic [7:0]             dq_out
);
    logic [7:0] mem [logic [22:0]];
    logic [7:0] last;
    logic [7:0] drv;
    logic       sel;
    assign sel = !pins.chip_select_low && pins.chip_select_high;
    always @(pins, dq_in) begin
        if (sel && !pins.write_enable_n)
            mem[pins.address_bus] = dq_in;
        if (sel && !pins.output_enable_n && pins.write_enable_n)
            last = mem.exists(pins.address_bus) ? mem[pins.address_bus] : 8'h00;
        drv = (sel && !pins.output_enable_n && pins.write_enable_n) ? last : ~last;
    end
    // slow answer: data settles after a delay
    assign #(DLY_NS) dq_out = drv;
endmodule

// ===== testbench/test_async_sram_8m_x8_array.sv
// bench: controller against a memory model
// assumes sxc_pkg and sxc_ctrl compiled first
`timescale 1ns/10ps
module test_async_sram_8m_x8_array;
    import sxc_pkg::*;
    logic clk, reset_n, req_valid, req_ready, rd_valid, data_bus_oe;
    sxc_req_t  req;
    sxc_pins_t pins;
    logic [7:0] rd_data, data_bus_out, mem_dq;
    wire  [7:0] dq = data_bus_oe ? data_bus_out : mem_dq;
    int n_mismatch = 0, compares = 0, cyc = 0;
    logic [22:0] ta [4] = '{23'h000000, 23'h7FFFFF, 23'h400000, 23'h000001};
    logic [7:0]  td [4] = '{8'h3C, 8'hC3, 8'h5A, 8'h96};
    sxc_ctrl #(.POWERUP_CYC(4)) dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
        .data_bus_in(dq), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
    sxc_mem_model #(.DLY_NS(3)) u_mem (.pins(pins), .dq_in(dq), .dq_out(mem_dq));
    // ------------------------------------------------------------
    // clock, timeout, compares
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    task check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hold the request until ready is seen at an edge
    task send(input logic w, input logic [22:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid <= 1'b0;
        check8({7'h00, req_ready}, 8'h01);
    endtask
    task read_back(input logic [22:0] a, input logic [7:0] exp);
        int n;
        send(1'b0, a, 8'h00);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 20);
        check8({7'h00, rd_valid}, 8'h01);
        check8(rd_data, exp);
    endtask
    // early request must wait out power-up untouched
    task t_powerup;
        int n;
        n = 0;
        req_valid <= 1'b1;
        req <= '{1'b1, 23'h7FFFFF, 8'hA5};
        reset_n <= 1'b1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
            check8({7'h00, pins.write_enable_n}, 8'h01);
        end
        req_valid <= 1'b0;
        check8({7'h00, n > 4}, 8'h01);
        read_back(23'h7FFFFF, 8'hA5);
    endtask
    // corner addresses, then a neighbour overwrite
    task t_table;
        for (int i = 0; i < 4; i++)
            send(1'b1, ta[i], td[i]);
        for (int i = 0; i < 4; i++)
            read_back(ta[i], td[i]);
        send(1'b1, 23'h000001, 8'hFF);
        read_back(23'h000000, 8'h3C);
        read_back(23'h000001, 8'hFF);
    endtask
    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (20) @(posedge clk);
        check8({7'h00, pins.chip_select_low}, 8'h01);
        t_powerup;
        t_table;
        wrap_up;
    end
endmodule
